// ==== inc/ams_pkg.sv ====
package ams_pkg;
  localparam int NAX = 4;
  localparam int CLK_MHZ = 10;
  localparam int CYC_NS = 1000;
  localparam int CYC_CNT = CYC_NS * CLK_MHZ / 1000;
  localparam logic [3:0] CYC_LAST = 4'(CYC_CNT - 1);
  // encoder pulses per 0.01 mm of tolerance
  localparam logic [15:0] PPC = 16'h0001;
  localparam logic [12:0] TOL_RST = 13'h0005;
  localparam logic [12:0] TOL_MIN = 13'h0001;
  localparam logic [12:0] TOL_MAX = 13'h1964;
  localparam logic [15:0] LIM_RST = 16'h4e20;
  localparam logic [15:0] LIM_MIN = 16'h0001;
  localparam logic [13:0] VMX_RST = 14'h04b0;
  localparam logic [13:0] VMX_MIN = 14'h0001;
  localparam logic [13:0] VMX_MAX = 14'h270f;
  // homing speeds held in 0.1 mm/s
  localparam logic [13:0] HS_MIN = 14'h000a;
  localparam logic [13:0] HLM_MAX = 14'h09c4;
  localparam logic [13:0] HH_MAX = 14'h2706;
  localparam logic [13:0] HL_RST = 14'h0014;
  localparam logic [13:0] HM_RST = 14'h00c8;
  localparam logic [13:0] HH_RST = 14'h03e8;
  localparam logic [13:0] TENTH = 14'h000a;
  localparam logic [2:0] METH_RST = 3'h0;
  localparam logic [2:0] METH_MAX = 3'h4;
  localparam logic [2:0] METH_ALIAS = 3'h4;
  localparam logic [2:0] METH_BASE = 3'h0;
  localparam logic [2:0] LBL_X = 3'h0;
  localparam logic [2:0] LBL_Q = 3'h4;
  localparam logic [3:0] ACC_DEF = 4'h5;
  localparam logic [1:0] OP_SERVO_ON_CMD = 2'h0;
  localparam logic [1:0] OP_SERVO_OFF_CMD = 2'h1;
  localparam logic [1:0] OP_OUTPUT_SET_CMD = 2'h2;
  // register index within an axis block, byte address = axis*0x20 + idx*4
  localparam logic [2:0] R_TOL = 3'h0;
  localparam logic [2:0] R_LIM = 3'h1;
  localparam logic [2:0] R_CFG = 3'h2;
  localparam logic [2:0] R_VMX = 3'h3;
  localparam logic [2:0] R_HL = 3'h4;
  localparam logic [2:0] R_HM = 3'h5;
  localparam logic [2:0] R_HH = 3'h6;
  localparam logic [2:0] R_STAT = 3'h7;
  localparam logic [7:0] CTRL_ADDR = 8'h80;
  localparam int A_CTL = 7;
  localparam int A_AX = 5;
  localparam int A_RG = 2;
  localparam int B_DIR = 0;
  localparam int B_POL = 1;
  localparam int B_USED = 2;
  localparam int B_METH = 4;
  localparam int B_LBL = 8;
  localparam int S_INPOS = 0;
  localparam int S_OVF = 1;
  localparam int S_DET = 2;
  localparam int S_SERVO_ON_CMD = 3;
  localparam int S_ACC = 4;
  localparam int S_LBL = 8;
  localparam int S_METH = 12;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic [12:0] tol;
    logic [15:0] lim;
    logic [13:0] vmx;
    logic [13:0] hl;
    logic [13:0] hm;
    logic [13:0] hh;
    logic [2:0]  meth;
    logic [2:0]  lab;
    logic        used;
    logic        pol;
    logic        dir;
  } ams_cfg_t;

  localparam ams_cfg_t CFG_RST = '{tol: TOL_RST, lim: LIM_RST, vmx: VMX_RST,
    hl: HL_RST, hm: HM_RST, hh: HH_RST, meth: METH_RST, lab: LBL_X,
    used: 1'b1, pol: 1'b1, dir: 1'b0};
endpackage

// ==== sim/ams_motor_model.sv ====
`timescale 1ns/1ps
module ams_motor_model (
  // clock
  input  wire logic             clk_in,
  // motion demand
  input  wire logic [3:0][31:0] tgt_in,
  input  wire logic [3:0][31:0] lag_in,
  // origin sensor
  input  wire logic [3:0]       at_home_in,
  input  wire logic [3:0]       low_act_in,
  // feedback
  output logic      [3:0][31:0] cur_pos_out,
  output logic      [3:0]       sensor_out
);
  // the shaft trails the target by the following error that the bench asks for
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      cur_pos_out[i] <= tgt_in[i] - lag_in[i];
    end
  end
  // a low-active sensor pulls its line low while it sees the dog
  assign sensor_out = at_home_in ^ low_act_in;
endmodule

// ==== sim/ams_top_test.sv ====
`timescale 1ns/1ps
module ams_top_test;
  logic             clk, rst_n, awv, wv, brd, arv, rrd, acc_sel, cv, awr, wr, bv, arr, rv;
  logic [7:0]       awa, ara;
  logic [31:0]      wd, rd;
  logic [1:0]       br, rr, cop;
  logic [2:0]       clab;
  logic [3:0][31:0] cmd, tgt, lag, cur;
  logic [3:0][13:0] spq, spd;
  logic [3:0][9:0]  hl, hm, hh;
  logic [3:0][2:0]  meth, lab;
  logic [3:0]       fwd, home, lact, sens, acc_tbl, inpos, ovf, cw, acct, det, servo_on_cmd, output_set_cmd, wst;
  logic [1:0]       wq[$];
  logic [33:0]      rq[$];
  integer           num_errors = 0, checks = 0, seed = 14;
  logic [31:0]      dv[7] = '{32'h5, 32'h4e20, 32'h6, 32'h4b0, 32'h14, 32'hc8, 32'h3e8};
  logic [39:0]      bt[8] = '{40'h0, 40'h1965, 40'h0400000000, 40'h0800000056, 40'h0c00002710,
                              40'h10000009c5, 40'h1800002707, 40'ha000000001};
  logic [18:0]      tb[6] = '{{16'h4, 3'b010}, {16'h5, 3'b000}, {16'h4, 3'b100},
                              {16'h4e20, 3'b000}, {16'h4e21, 3'b001}, {16'h0, 3'b011}};
  ////////////////////////////////////////////////////////////////
  ams_top ams_top_i (.MCLK_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(wst), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wr), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(brd),
    .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rd),
    .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rrd), .CMD_POS_IN(cmd), .TGT_POS_IN(tgt),
    .CUR_POS_IN(cur), .MOVE_FWD_IN(fwd), .SPEED_REQ_IN(spq), .HOME_SENSOR_IN(sens),
    .ACC_SEL_IN(acc_sel), .ACC_TBL_IN(acc_tbl), .CMD_VALID_IN(cv), .CMD_OP_IN(cop),
    .CMD_LABEL_IN(clab), .INPOS_OUT(inpos), .OVF_ERR_OUT(ovf), .MOTOR_CW_OUT(cw), .SPEED_OUT(spd),
    .HOME_SPD_L_OUT(hl), .HOME_SPD_M_OUT(hm), .HOME_SPD_H_OUT(hh), .HOME_ACC_TBL_OUT(acct),
    .HOME_METH_OUT(meth), .HOME_DET_OUT(det), .AXIS_LABEL_OUT(lab), .SERVO_ON_OUT(servo_on_cmd),
    .OUT_SET_OUT(output_set_cmd));
  ams_motor_model ams_motor_model_i (.clk_in(clk), .tgt_in(tgt), .lag_in(lag), .at_home_in(home),
    .low_act_in(lact), .cur_pos_out(cur), .sensor_out(sens));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // one bus transfer; the note of the expected answer goes to the watcher
  task automatic ax(input logic rdo, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    integer n;
    logic [2:0] p, k;
    p = rdo ? 3'b001 : 3'b110;
    @(posedge clk);
    if (rdo) begin
      rq.push_back({r, d});
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
    end else begin
      wq.push_back(r);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
    end
    for (n = 0; n < 60 && p != 3'b000; n++) begin
      @(negedge clk);
      k = {awv & awr, wv & wr, arv & arr} & p;
      @(posedge clk);
      if (k[2]) awv <= 1'b0;
      if (k[1]) wv <= 1'b0;
      if (k[0]) arv <= 1'b0;
      p = p & ~k;
    end
    for (n = n; n < 60 && !(rdo ? rv : bv); n++) @(negedge clk);
    if (n >= 60) begin
      num_errors++;
      complete_run();
    end else begin
      @(posedge clk);
      brd <= 1'b0;
      rrd <= 1'b0;
    end
  endtask
  task automatic cm(input logic [1:0] op, input logic [2:0] lb);
    @(posedge clk);
    cv <= 1'b1;
    cop <= op;
    clab <= lb;
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (bv && brd && wq.size() > 0) cmp(34'(br), 34'(wq.pop_front()));
    if (rv && rrd && rq.size() > 0) cmp({rr, rd}, rq.pop_front());
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {awv, wv, brd, arv, rrd, acc_sel, cv, cop, awa, ara, wd, acc_tbl, clab} = '0;
    wst = 4'hf;
    {cmd, tgt, lag} = '0;
    tgt[2] = 32'h3e8;
    fwd = 4'hf;
    home = 4'h3;
    lact = 4'hd;
    for (int i = 0; i < 4; i++) spq[i] = 14'($random(seed)) & 14'h00ff;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    w(4);
    cmp(34'(acct), 34'h5);
    cmp(34'(meth[0]), 34'h0);
    for (int i = 0; i < 7; i++) ax(1'b1, 8'(i * 4), dv[i], 2'h0);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) ax(1'b0, bt[i][39:32], bt[i][31:0], 2'h2);
    ax(1'b1, 8'ha0, 32'h0, 2'h2);
    ax(1'b0, 8'h00, 32'h1964, 2'h0);
    ax(1'b1, 8'h00, 32'h1964, 2'h0);
    // only the low byte is enabled: the rest of the stored limit survives
    @(posedge clk);
    wst <= 4'h1;
    ax(1'b0, 8'h64, 32'h1234, 2'h0);
    wst <= 4'hf;
    ax(1'b1, 8'h64, 32'h4e34, 2'h0);
    $display("test ranges done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      lag[2] <= 32'(tb[i][18:3]);
      cmd[2] <= 32'h3e8 - 32'(tb[i][2]);
      w(22);
      cmp(34'(inpos[2]), 34'(tb[i][1]));
      cmp(34'(ovf[2]), 34'(tb[i][0]));
    end
    ax(1'b0, 8'h5c, 32'h2, 2'h0);
    w(2);
    cmp(34'(ovf[2]), 34'h0);
    $display("test supervision done");
    ax(1'b0, 8'h28, 32'h45, 2'h0);
    ax(1'b0, 8'h2c, 32'h64, 2'h0);
    ax(1'b0, 8'h38, 32'h4d7, 2'h0);
    ax(1'b0, 8'h30, 32'h19, 2'h0);
    w(4);
    cmp(34'(cw[1]), 34'h1);
    cmp(34'(det[1]), 34'h0);
    cm(ams_pkg::OP_SERVO_ON_CMD, 3'h0);
    cmp(34'(servo_on_cmd), 34'h1);
    cm(ams_pkg::OP_OUTPUT_SET_CMD, 3'h0);
    cmp(34'(output_set_cmd), 34'h1);
    @(posedge clk);
    acc_sel <= 1'b1;
    acc_tbl <= 4'h3;
    @(posedge clk);
    acc_sel <= 1'b0;
    w(1);
    cmp(34'(acct), 34'h3);
    ax(1'b0, 8'h80, 32'h1, 2'h0);
    w(4);
    cmp(34'(cw[1]), 34'h0);
    cmp(34'(det[1:0]), 34'h3);
    cmp(34'(meth[1]), 34'h0);
    cmp(34'(hh[1]), 34'h64);
    cmp(34'(hl[1]), 34'h2);
    cmp(34'(hm[1]), 34'h14);
    cmp(34'(spd[1]), 34'((spq[1] > 14'h64) ? 14'h64 : spq[1]));
    cmp(34'(spd[0]), 34'(spq[0]));
    ax(1'b0, 8'h08, 32'h2, 2'h0);
    ax(1'b0, 8'h80, 32'h1, 2'h0);
    w(4);
    cmp(34'(lab[1:0]), 34'h4);
    cm(ams_pkg::OP_SERVO_ON_CMD, 3'h0);
    cmp(34'(servo_on_cmd[1]), 34'h1);
    // the unused axis keeps its servo state: the label goes to the used one
    cm(ams_pkg::OP_SERVO_OFF_CMD, 3'h0);
    cmp(34'(servo_on_cmd), 34'h1);
    cm(ams_pkg::OP_SERVO_ON_CMD, ams_pkg::LBL_Q);
    cmp(34'(servo_on_cmd), 34'h1);
    cm(2'h3, 3'h0);
    cmp(34'({output_set_cmd, servo_on_cmd}), 34'h01);
    @(posedge clk);
    fwd <= 4'h0;
    w(2);
    cmp(34'(cw[1:0]), 34'h2);
    $display("test settings done");
    complete_run();
  end
endmodule

// ==== verilog/ams_axis_check.sv ====
`timescale 1ns/1ps
module ams_axis_check (
  // clock and reset
  input  logic        clk_in,
  input  logic        rst_n_in,
  // control cycle and settings
  input  logic        tick_in,
  input  logic [12:0] tol_in,
  input  logic [15:0] lim_in,
  input  logic        clr_in,
  // positions
  input  logic [31:0] cmd_pos_in,
  input  logic [31:0] tgt_pos_in,
  input  logic [31:0] cur_pos_in,
  // results
  output logic        inpos_out,
  output logic        ovf_out
);
  typedef struct packed {
    logic [31:0] defl;
    logic        inpos;
    logic        ovf;
  } ams_chk_t;

  ams_chk_t    q;
  ams_chk_t    d;
  logic [31:0] diff;
  logic [31:0] mag;
  logic [31:0] tolp;

  always_comb begin
    diff = tgt_pos_in - cur_pos_in;
    mag = diff[31] ? (32'h0000_0000 - diff) : diff;
    tolp = 32'(tol_in) * 32'(ams_pkg::PPC);
    d = q;
    if (tick_in) begin
      d.defl = mag;
      d.inpos = (cmd_pos_in == tgt_pos_in) && (mag < tolp);
    end
    // a fresh overflow beats a software clear in the same cycle
    if (tick_in && (mag > 32'(lim_in))) begin
      d.ovf = 1'b1;
    end else if (clr_in) begin
      d.ovf = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign inpos_out = q.inpos;
  assign ovf_out = q.ovf;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_inpos_cmd: assert property ($rose(inpos_out) |-> $past(tick_in && cmd_pos_in == tgt_pos_in))
    else $error("in-position without command at target");
  a_inpos_tol: assert property (tick_in && mag >= tolp |=> !inpos_out)
    else $error("in-position with deflection at tolerance");
  a_ovf_raise: assert property (tick_in && mag > 32'(lim_in) |=> ovf_out)
    else $error("overflow not raised");
  a_ovf_hold: assert property (ovf_out && !clr_in |=> ovf_out)
    else $error("overflow dropped without clear");
  a_eval_tick: assert property (!tick_in |=> $stable(q.defl) && $stable(inpos_out))
    else $error("evaluation outside control cycle");
  c_ovf_seen: cover property ($rose(ovf_out));
  c_inpos_seen: cover property ($rose(inpos_out));
endmodule

// ==== verilog/ams_top.sv ====
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module ams_top (
  // clock and reset
  input  logic             MCLK_IN,
  input  logic             RST_N_IN,
  // axi4-lite write
  input  logic [7:0]       AXI_AWADDR_IN,
  input  logic             AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  input  logic [31:0]      AXI_WDATA_IN,
  input  logic [3:0]       AXI_WSTRB_IN,
  input  logic             AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  logic             AXI_BREADY_IN,
  // axi4-lite read
  input  logic [7:0]       AXI_ARADDR_IN,
  input  logic             AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  logic             AXI_RREADY_IN,
  // motion state per axis
  input  logic [3:0][31:0] CMD_POS_IN,
  input  logic [3:0][31:0] TGT_POS_IN,
  input  logic [3:0][31:0] CUR_POS_IN,
  input  logic [3:0]       MOVE_FWD_IN,
  input  logic [3:0][13:0] SPEED_REQ_IN,
  input  logic [3:0]       HOME_SENSOR_IN,
  // commands
  input  logic             ACC_SEL_IN,
  input  logic [3:0]       ACC_TBL_IN,
  input  logic             CMD_VALID_IN,
  input  logic [1:0]       CMD_OP_IN,
  input  logic [2:0]       CMD_LABEL_IN,
  // supervision results, drive and homing outputs
  output logic [3:0]       INPOS_OUT,
  output logic [3:0]       OVF_ERR_OUT,
  output logic [3:0]       MOTOR_CW_OUT,
  output logic [3:0][13:0] SPEED_OUT,
  output logic [3:0][9:0]  HOME_SPD_L_OUT,
  output logic [3:0][9:0]  HOME_SPD_M_OUT,
  output logic [3:0][9:0]  HOME_SPD_H_OUT,
  output logic [3:0]       HOME_ACC_TBL_OUT,
  output logic [3:0][2:0]  HOME_METH_OUT,
  output logic [3:0]       HOME_DET_OUT,
  output logic [3:0][2:0]  AXIS_LABEL_OUT,
  output logic [3:0]       SERVO_ON_OUT,
  output logic [3:0]       OUT_SET_OUT
);
  typedef enum logic [2:0] {
    AX_IDLE = 3'b001,
    AX_BRSP = 3'b010,
    AX_RRSP = 3'b100
  } ams_bus_t;

  typedef struct packed {
    ams_bus_t                      bus;
    logic                          aw_f;
    logic                          w_f;
    logic [7:0]                    awa;
    logic [31:0]                   wd;
    logic [3:0]                    ws;
    logic [1:0]                    resp;
    logic [31:0]                   rd;
    ams_pkg::ams_cfg_t [3:0]       pend;
    ams_pkg::ams_cfg_t [3:0]       act;
    logic [3:0]                    s1;
    logic [3:0]                    s2;
    logic [3:0]                    acc;
    logic [3:0]                    clr;
    logic [3:0]                    cnt;
    logic                          tick;
    logic [3:0]                    servo_on_cmd;
    logic [3:0]                    output_set_cmd;
    logic [3:0]                    cw;
    logic [3:0]                    det;
    logic [3:0][13:0]              spd;
    logic [3:0][9:0]               ol;
    logic [3:0][9:0]               om;
    logic [3:0][9:0]               oh;
    logic [3:0][2:0]               lab;
    logic [3:0][2:0]               meth;
  } ams_st_t;

  ams_st_t    q;
  ams_st_t    d;
  logic [3:0] inpos;
  logic [3:0] ovf;

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < ams_pkg::NAX; g++) begin : gen_ax
      ams_axis_check u_chk (
        .clk_in     (MCLK_IN),
        .rst_n_in   (RST_N_IN),
        .tick_in    (q.tick),
        .tol_in     (q.act[g].tol),
        .lim_in     (q.act[g].lim),
        .clr_in     (q.clr[g]),
        .cmd_pos_in (CMD_POS_IN[g]),
        .tgt_pos_in (TGT_POS_IN[g]),
        .cur_pos_in (CUR_POS_IN[g]),
        .inpos_out  (inpos[g]),
        .ovf_out    (ovf[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // whole mm/s, never above the axis maximum
  function automatic logic [9:0] hclamp(input logic [13:0] x, input logic [13:0] vmx);
    logic [13:0] t;
    t = x / ams_pkg::TENTH;
    if (t > vmx) begin
      t = vmx;
    end
    return t[9:0];
  endfunction

  // reads show the stored (pending) settings and the live status
  function automatic logic [31:0] rword(input logic [1:0] a, input logic [2:0] r);
    logic [31:0]       w;
    ams_pkg::ams_cfg_t c;
    w = '0;
    c = q.pend[a];
    unique case (r)
      ams_pkg::R_TOL: w[12:0] = c.tol;
      ams_pkg::R_LIM: w[15:0] = c.lim;
      ams_pkg::R_CFG: begin
        w[ams_pkg::B_DIR] = c.dir;
        w[ams_pkg::B_POL] = c.pol;
        w[ams_pkg::B_USED] = c.used;
        w[ams_pkg::B_METH +: 3] = c.meth;
        w[ams_pkg::B_LBL +: 3] = c.lab;
      end
      ams_pkg::R_VMX: w[13:0] = c.vmx;
      ams_pkg::R_HL: w[13:0] = c.hl;
      ams_pkg::R_HM: w[13:0] = c.hm;
      ams_pkg::R_HH: w[13:0] = c.hh;
      ams_pkg::R_STAT: begin
        w[ams_pkg::S_INPOS] = inpos[a];
        w[ams_pkg::S_OVF] = ovf[a];
        w[ams_pkg::S_DET] = q.det[a];
        w[ams_pkg::S_SERVO_ON_CMD] = q.servo_on_cmd[a];
        w[ams_pkg::S_ACC +: 4] = q.acc;
        w[ams_pkg::S_LBL +: 3] = q.lab[a];
        w[ams_pkg::S_METH +: 3] = q.meth[a];
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0]        ax;
    logic [2:0]        rg;
    logic [31:0]       m;
    logic [31:0]       v;
    logic              ok;
    logic              hit;
    ams_pkg::ams_cfg_t c;
    ax = q.awa[ams_pkg::A_AX +: 2];
    rg = q.awa[ams_pkg::A_RG +: 3];
    m = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};
    v = (rword(ax, rg) & ~m) | (q.wd & m);
    ok = 1'b1;
    hit = 1'b0;
    c = q.act[0];
    d = q;
    d.clr = '0;
    d.output_set_cmd = '0;
    d.tick = 1'b0;
    d.s1 = HOME_SENSOR_IN;
    d.s2 = q.s1;
    if (q.cnt == ams_pkg::CYC_LAST) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
    if (ACC_SEL_IN) begin
      d.acc = ACC_TBL_IN;
    end
    if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      d.aw_f = 1'b1;
      d.awa = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      d.w_f = 1'b1;
      d.wd = AXI_WDATA_IN;
      d.ws = AXI_WSTRB_IN;
    end
    unique case (q.bus)
      AX_IDLE: begin
        if (q.aw_f && q.w_f) begin
          d.aw_f = 1'b0;
          d.w_f = 1'b0;
          d.bus = AX_BRSP;
          if (q.awa == ams_pkg::CTRL_ADDR) begin
            // restart: stored settings become the working ones
            if (m[0] && q.wd[0]) begin
              d.act = q.pend;
            end
          end else if (q.awa[ams_pkg::A_CTL]) begin
            ok = 1'b0;
          end else begin
            // out-of-range values are refused and the old value kept
            unique case (rg)
              ams_pkg::R_TOL: begin
                ok = v[31:13] == '0 && v[12:0] >= ams_pkg::TOL_MIN && v[12:0] <= ams_pkg::TOL_MAX;
                if (ok) d.pend[ax].tol = v[12:0];
              end
              ams_pkg::R_LIM: begin
                ok = v[31:16] == '0 && v[15:0] >= ams_pkg::LIM_MIN;
                if (ok) d.pend[ax].lim = v[15:0];
              end
              ams_pkg::R_CFG: begin
                ok = v[ams_pkg::B_METH +: 3] <= ams_pkg::METH_MAX && v[ams_pkg::B_LBL +: 3] <= ams_pkg::LBL_Q;
                if (ok) begin
                  d.pend[ax].dir = v[ams_pkg::B_DIR];
                  d.pend[ax].pol = v[ams_pkg::B_POL];
                  d.pend[ax].used = v[ams_pkg::B_USED];
                  d.pend[ax].meth = v[ams_pkg::B_METH +: 3];
                  d.pend[ax].lab = v[ams_pkg::B_LBL +: 3];
                end
              end
              ams_pkg::R_VMX: begin
                ok = v[31:14] == '0 && v[13:0] >= ams_pkg::VMX_MIN && v[13:0] <= ams_pkg::VMX_MAX;
                if (ok) d.pend[ax].vmx = v[13:0];
              end
              ams_pkg::R_HL: begin
                ok = v[31:14] == '0 && v[13:0] >= ams_pkg::HS_MIN && v[13:0] <= ams_pkg::HLM_MAX;
                if (ok) d.pend[ax].hl = v[13:0];
              end
              ams_pkg::R_HM: begin
                ok = v[31:14] == '0 && v[13:0] >= ams_pkg::HS_MIN && v[13:0] <= ams_pkg::HLM_MAX;
                if (ok) d.pend[ax].hm = v[13:0];
              end
              ams_pkg::R_HH: begin
                ok = v[31:14] == '0 && v[13:0] >= ams_pkg::HS_MIN && v[13:0] <= ams_pkg::HH_MAX;
                if (ok) d.pend[ax].hh = v[13:0];
              end
              ams_pkg::R_STAT: d.clr[ax] = m[ams_pkg::S_OVF] && q.wd[ams_pkg::S_OVF];
            endcase
          end
          d.resp = ok ? ams_pkg::RESP_OK : ams_pkg::RESP_ERR;
        end else if (AXI_ARVALID_IN) begin
          d.bus = AX_RRSP;
          d.rd = '0;
          d.resp = ams_pkg::RESP_OK;
          if (AXI_ARADDR_IN == ams_pkg::CTRL_ADDR) begin
            d.rd = '0;
          end else if (AXI_ARADDR_IN[ams_pkg::A_CTL]) begin
            d.resp = ams_pkg::RESP_ERR;
          end else begin
            d.rd = rword(AXI_ARADDR_IN[ams_pkg::A_AX +: 2], AXI_ARADDR_IN[ams_pkg::A_RG +: 3]);
          end
        end
      end
      AX_BRSP: if (AXI_BREADY_IN) d.bus = AX_IDLE;
      AX_RRSP: if (AXI_RREADY_IN) d.bus = AX_IDLE;
    endcase
    // only the lowest station carrying the label acts
    if (CMD_VALID_IN && CMD_LABEL_IN != ams_pkg::LBL_Q) begin
      for (int a = 0; a < ams_pkg::NAX; a++) begin
        if (!hit && q.act[a].used && q.act[a].lab == CMD_LABEL_IN) begin
          hit = 1'b1;
          unique case (CMD_OP_IN)
            ams_pkg::OP_SERVO_ON_CMD: d.servo_on_cmd[a] = 1'b1;
            ams_pkg::OP_SERVO_OFF_CMD: d.servo_on_cmd[a] = 1'b0;
            ams_pkg::OP_OUTPUT_SET_CMD: d.output_set_cmd[a] = 1'b1;
            default: d.output_set_cmd[a] = 1'b0;
          endcase
        end
      end
    end
    for (int a = 0; a < ams_pkg::NAX; a++) begin
      c = q.act[a];
      d.cw[a] = MOVE_FWD_IN[a] ^ c.dir;
      d.spd[a] = (SPEED_REQ_IN[a] > c.vmx) ? c.vmx : SPEED_REQ_IN[a];
      d.ol[a] = hclamp(c.hl, c.vmx);
      d.om[a] = hclamp(c.hm, c.vmx);
      d.oh[a] = hclamp(c.hh, c.vmx);
      d.meth[a] = (c.meth == ams_pkg::METH_ALIAS) ? ams_pkg::METH_BASE : c.meth;
      d.det[a] = c.pol ? ~q.s2[a] : q.s2[a];
      d.lab[a] = c.used ? c.lab : ams_pkg::LBL_Q;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q <= '0;
      q.bus <= AX_IDLE;
      q.pend <= {ams_pkg::NAX{ams_pkg::CFG_RST}};
      q.act <= {ams_pkg::NAX{ams_pkg::CFG_RST}};
      q.acc <= ams_pkg::ACC_DEF;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign AXI_AWREADY_OUT = q.bus == AX_IDLE && !q.aw_f;
  assign AXI_WREADY_OUT = q.bus == AX_IDLE && !q.w_f;
  assign AXI_ARREADY_OUT = q.bus == AX_IDLE && !(q.aw_f && q.w_f);
  assign AXI_BVALID_OUT = q.bus == AX_BRSP;
  assign AXI_RVALID_OUT = q.bus == AX_RRSP;
  assign AXI_BRESP_OUT = q.resp;
  assign AXI_RRESP_OUT = q.resp;
  assign AXI_RDATA_OUT = q.rd;
  assign INPOS_OUT = inpos;
  assign OVF_ERR_OUT = ovf;
  assign MOTOR_CW_OUT = q.cw;
  assign SPEED_OUT = q.spd;
  assign HOME_SPD_L_OUT = q.ol;
  assign HOME_SPD_M_OUT = q.om;
  assign HOME_SPD_H_OUT = q.oh;
  assign HOME_ACC_TBL_OUT = q.acc;
  assign HOME_METH_OUT = q.meth;
  assign HOME_DET_OUT = q.det;
  assign AXIS_LABEL_OUT = q.lab;
  assign SERVO_ON_OUT = q.servo_on_cmd;
  assign OUT_SET_OUT = q.output_set_cmd;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_tol_range: assert property (q.pend[0].tol >= ams_pkg::TOL_MIN && q.pend[0].tol <= ams_pkg::TOL_MAX)
    else $error("tolerance out of range");
  a_lim_range: assert property (q.pend[0].lim >= ams_pkg::LIM_MIN)
    else $error("overflow limit zero");
  a_dir_sense: assert property (MOVE_FWD_IN[0] && !q.act[0].dir |=> MOTOR_CW_OUT[0])
    else $error("forward move not clockwise");
  a_speed_clamp: assert property (SPEED_REQ_IN[1] > q.act[1].vmx |=> SPEED_OUT[1] == $past(q.act[1].vmx))
    else $error("speed not clamped");
  a_home_range: assert property (q.pend[0].hl <= ams_pkg::HLM_MAX && q.pend[0].hh <= ams_pkg::HH_MAX)
    else $error("homing speed out of range");
  a_home_trunc: assert property (##1 14'(HOME_SPD_H_OUT[0]) <= $past(q.act[0].hh) / ams_pkg::TENTH)
    else $error("homing speed not truncated");
  a_acc_keep: assert property (!ACC_SEL_IN |=> $stable(HOME_ACC_TBL_OUT))
    else $error("accel table changed without select");
  a_meth_range: assert property (q.pend[0].meth <= ams_pkg::METH_MAX)
    else $error("method code out of range");
  a_meth_alias: assert property (HOME_METH_OUT[1] != ams_pkg::METH_ALIAS)
    else $error("method four not mapped");
  a_pol_det: assert property (q.act[0].pol && !q.s2[0] |=> HOME_DET_OUT[0])
    else $error("low sensor not detected");
  a_lab_unused: assert property (!q.act[0].used |=> AXIS_LABEL_OUT[0] == ams_pkg::LBL_Q)
    else $error("unused axis label shown");
  a_servo_on_cmd_lowest: assert property (CMD_VALID_IN && CMD_OP_IN == ams_pkg::OP_SERVO_ON_CMD && !SERVO_ON_OUT[1]
      && q.act[0].used && q.act[1].used && q.act[0].lab == q.act[1].lab
      && q.act[0].lab == CMD_LABEL_IN |=> !SERVO_ON_OUT[1])
    else $error("higher station served");
  a_apply_gate: assert property (!(q.bus == AX_IDLE && q.aw_f && q.w_f) |=> $stable(q.act))
    else $error("settings applied without restart");
  a_bvalid_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT)
    else $error("write response dropped");
  c_write_done: cover property (AXI_BVALID_OUT && AXI_BREADY_IN);
  c_read_done: cover property (AXI_RVALID_OUT && AXI_RREADY_IN);
  c_restart: cover property ($changed(q.act));
endmodule
